// ---- rtl/scsfw_consts.svh ----
// Constants for the system clock select and fast wake block
`ifndef SCSFW_CONSTS_SVH
`define SCSFW_CONSTS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define SCSFW_OFF_MODE      5'h00
`define SCSFW_OFF_IRQ_STAT  5'h04
`define SCSFW_OFF_IRQ_EN    5'h08
`define SCSFW_OFF_IRQ_CLR   5'h0c
`define SCSFW_OFF_AUX       5'h10
`define SCSFW_OFF_STATE     5'h14

// ************************************************************
// Mode register fields
// ************************************************************
`define SCSFW_DIV_MSB       7
`define SCSFW_DIV_LSB       5
`define SCSFW_FAST_BIT      4
`define SCSFW_LRDY_BIT      3
`define SCSFW_HRDY_BIT      2
`define SCSFW_IDLE_BIT      1
`define SCSFW_HSEL_BIT      0
`define SCSFW_MODE_RST      8'h03
`define SCSFW_DIV_FIRST_HI  3'h2
`define SCSFW_DIV_SHIFT_TOP 4'h8

// Aux register: bit 0 keeps clock in idle, bit 1 watchdog on
`define SCSFW_KEEP_BIT      0
`define SCSFW_WDT_BIT       1
`define SCSFW_AUX_RST       2'h2

// Event bits: high ready, low ready, suspended, woken
`define SCSFW_EV_HRDY       0
`define SCSFW_EV_LRDY       1
`define SCSFW_EV_HALT       2
`define SCSFW_EV_WAKE       3
`define SCSFW_NUM_EV        4

// ************************************************************
// Oscillator cycle counts
// ************************************************************
`define SCSFW_XTAL_CYCLES   11'h400
`define SCSFW_RC_CYCLES     11'h010
`define SCSFW_SHORT_CYCLES  11'h002

`endif

// ---- rtl/scsfw_pkg.sv ----
// Types shared by the clock select and fast wake block
package scsfw_pkg;
    typedef enum logic [2:0] {
        ST_RUN, ST_CPU_OFF_SYSCLK_OFF_MODE, ST_CPU_OFF_SYSCLK_ON_MODE, ST_FULL_STOP_MODE, ST_STOP_WITH_SUB_CLOCK_MODE,
        ST_WAKE, ST_WAKE_SHORT, ST_FAST
    } scsfw_state_type;

    typedef enum logic [1:0] {
        SRC_HIGH, SRC_LOW, SRC_SUB, SRC_NONE
    } scsfw_src_type;

    typedef enum logic [1:0] {
        HO_CRYSTAL, HO_EXT_RC, HO_EXT_CLK, HO_INT_RC
    } scsfw_hosc_type;
endpackage

// ---- rtl/scsfw_tick_cnt.sv ----
// Counts oscillator ticks up to a limit and flags completion
`timescale 1ns/1ps
`default_nettype none
module scsfw_tick_cnt #(
    parameter int WIDTH = 11
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Counting
    input  wire logic             clear,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  done_q
);
    logic [WIDTH-1:0] cnt_q;
    wire              last = (cnt_q == limit - 1'b1);

    if (WIDTH < 2) begin : g_chk
        $error("scsfw_tick_cnt: WIDTH too small");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                cnt_q  <= '0;
                done_q <= 1'b0;
            end else if (tick && !done_q) begin
                cnt_q  <= last ? '0 : cnt_q + 1'b1;
                done_q <= last;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/scsfw_top.sv ----
// System clock select, oscillator ready tracking and fast wake
`timescale 1ns/1ps
`default_nettype none
`include "scsfw_consts.svh"

module scsfw_top #(
    parameter int CNT_W = 11
) (
    // Clock, reset, enable
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // Avalon-MM slave
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // CPU requests
    input  wire logic        HALT_REQ,
    input  wire logic        WAKE_REQ,
    // Oscillator pins and option straps
    input  wire logic        OSC_HIGH_IN,
    input  wire logic        OSC_LOW_IN,
    input  wire logic [1:0]  HIGH_OSC_KIND,
    input  wire logic        LOW_OSC_KIND,
    // Clock control
    output logic      [1:0]  SYS_CLK_SRC,
    output logic      [2:0]  SYS_DIV_SHIFT,
    output logic             HIGH_OSC_EN,
    output logic             LOW_OSC_EN,
    output logic             CPU_RUN,
    output logic             SYS_CLK_RUN,
    output logic      [2:0]  MODE_STATE,
    output logic             IRQ
);
    localparam int NEV = `SCSFW_NUM_EV;

    if (CNT_W < 11) begin : g_chk
        $error("scsfw_top: CNT_W cannot hold 1024");
    end

    // ************************************************************
    // Registers and state
    // ************************************************************
    logic [7:0]                 mode_q;
    logic [1:0]                 aux_q;
    logic [NEV-1:0]             stat_q, en_q;
    logic                       wait_q, irq_q;
    logic [31:0]                rdata_q;
    scsfw_pkg::scsfw_state_type state_q, state_d;
    scsfw_pkg::scsfw_src_type   src_q, src_d;
    logic [2:0]                 div_q;
    logic                       hen_q, len_q, cpu_q, sclk_q;
    logic                       sfast_q, sfast_d;
    logic                       hrdy_p_q, lrdy_p_q;
    logic                       high_rdy, low_rdy, hold_done;
    logic [1:0]                 tick;

    // ************************************************************
    // Oscillator pin synchronisers
    // ************************************************************
    wire [1:0] osc_pin = {OSC_LOW_IN, OSC_HIGH_IN};

    for (genvar g = 0; g < 2; g++) begin : g_sync
        logic s1_q, s2_q, s3_q;
        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
            end else if (CE) begin
                s1_q <= osc_pin[g];
                s2_q <= s1_q;
                s3_q <= s2_q;
            end
        end
        // Edge taken between stages two and three only
        assign tick[g] = s2_q & ~s3_q;
    end

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire req    = AVS_READ | AVS_WRITE;
    wire acc    = req & ~wait_q;
    wire wr_lo  = AVS_WRITE & acc & AVS_BYTEENABLE[0];
    wire sel_md = AVS_ADDRESS == `SCSFW_OFF_MODE;
    wire sel_st = AVS_ADDRESS == `SCSFW_OFF_IRQ_STAT;
    wire sel_en = AVS_ADDRESS == `SCSFW_OFF_IRQ_EN;
    wire sel_cl = AVS_ADDRESS == `SCSFW_OFF_IRQ_CLR;
    wire sel_ax = AVS_ADDRESS == `SCSFW_OFF_AUX;
    wire sel_sv = AVS_ADDRESS == `SCSFW_OFF_STATE;
    wire [7:0] wd = AVS_WRITEDATA[7:0];

    wire [2:0] cks       = mode_q[`SCSFW_DIV_MSB:`SCSFW_DIV_LSB];
    wire       hsel      = mode_q[`SCSFW_HSEL_BIT];
    wire       idle_on   = mode_q[`SCSFW_IDLE_BIT];
    wire       fast_en   = mode_q[`SCSFW_FAST_BIT];
    wire       keep      = aux_q[`SCSFW_KEEP_BIT];
    wire       wdt_en    = aux_q[`SCSFW_WDT_BIT];
    wire       div_hi    = cks >= `SCSFW_DIV_FIRST_HI;
    wire       tgt_high  = hsel | div_hi;
    wire [2:0] shift_d   = hsel ? 3'h0
                         : 3'(`SCSFW_DIV_SHIFT_TOP - {1'b0, cks});
    wire       is_xtal   = scsfw_pkg::scsfw_hosc_type'(HIGH_OSC_KIND)
                           == scsfw_pkg::HO_CRYSTAL;
    wire       fast_ok   = fast_en & tgt_high & is_xtal;
    wire       in_run    = state_q == scsfw_pkg::ST_RUN;
    wire       halt_go   = in_run & HALT_REQ;

    wire [7:0] mode_rd = {mode_q[7:4], low_rdy, high_rdy, mode_q[1:0]};
    wire [7:0] rd_val  = sel_md ? mode_rd
                       : sel_st ? 8'(stat_q)
                       : sel_en ? 8'(en_q)
                       : sel_ax ? {6'h00, aux_q}
                       : sel_sv ? {3'h0, src_q, state_q}
                       : 8'h00;

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
            mode_q  <= `SCSFW_MODE_RST;
            aux_q   <= `SCSFW_AUX_RST;
            en_q    <= '0;
        end else if (CE) begin
            wait_q <= ~(req & wait_q);
            if (AVS_READ & wait_q) begin
                rdata_q <= {24'h00_0000, rd_val};
            end
            if (wr_lo & sel_md) begin
                mode_q <= {wd[7:4], 2'b00, wd[1:0]};
            end
            if (wr_lo & sel_ax) begin
                aux_q <= wd[1:0];
            end
            if (wr_lo & sel_en) begin
                en_q <= wd[NEV-1:0];
            end
        end
    end

    // ************************************************************
    // Ready and hold counters
    // ************************************************************
    wire [CNT_W-1:0] hlim = CNT_W'(is_xtal ? `SCSFW_XTAL_CYCLES
                                           : `SCSFW_RC_CYCLES);
    wire [CNT_W-1:0] llim = CNT_W'(LOW_OSC_KIND ? `SCSFW_SHORT_CYCLES
                                                : `SCSFW_XTAL_CYCLES);
    wire             hold_tick = (sfast_q || src_q == scsfw_pkg::SRC_LOW)
                                 ? tick[1] : tick[0];
    wire             in_short  = state_q == scsfw_pkg::ST_WAKE_SHORT;

    scsfw_tick_cnt #(.WIDTH(CNT_W)) u_high_rdy (
        .clk    (CLK_SYS),
        .rst_n  (RST_N),
        .ce     (CE),
        .clear  (~hen_q),
        .tick   (tick[0]),
        .limit  (hlim),
        .done_q (high_rdy)
    );

    scsfw_tick_cnt #(.WIDTH(CNT_W)) u_low_rdy (
        .clk    (CLK_SYS),
        .rst_n  (RST_N),
        .ce     (CE),
        .clear  (~len_q),
        .tick   (tick[1]),
        .limit  (llim),
        .done_q (low_rdy)
    );

    scsfw_tick_cnt #(.WIDTH(CNT_W)) u_hold (
        .clk    (CLK_SYS),
        .rst_n  (RST_N),
        .ce     (CE),
        .clear  (~in_short),
        .tick   (hold_tick),
        .limit  (CNT_W'(`SCSFW_SHORT_CYCLES)),
        .done_q (hold_done)
    );

    // ************************************************************
    // Mode sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        sfast_d = sfast_q;
        case (state_q)
            scsfw_pkg::ST_RUN: begin
                if (HALT_REQ) begin
                    if (idle_on) begin
                        state_d = keep ? scsfw_pkg::ST_CPU_OFF_SYSCLK_ON_MODE
                                       : scsfw_pkg::ST_CPU_OFF_SYSCLK_OFF_MODE;
                    end else begin
                        state_d = wdt_en ? scsfw_pkg::ST_STOP_WITH_SUB_CLOCK_MODE
                                         : scsfw_pkg::ST_FULL_STOP_MODE;
                    end
                end
            end
            scsfw_pkg::ST_CPU_OFF_SYSCLK_ON_MODE: begin
                if (WAKE_REQ) begin
                    state_d = scsfw_pkg::ST_WAKE_SHORT;
                    sfast_d = 1'b0;
                end
            end
            scsfw_pkg::ST_CPU_OFF_SYSCLK_OFF_MODE, scsfw_pkg::ST_STOP_WITH_SUB_CLOCK_MODE: begin
                if (WAKE_REQ) begin
                    state_d = fast_ok ? scsfw_pkg::ST_WAKE_SHORT
                                      : scsfw_pkg::ST_WAKE;
                    sfast_d = fast_ok;
                end
            end
            scsfw_pkg::ST_FULL_STOP_MODE: begin
                if (WAKE_REQ) begin
                    state_d = scsfw_pkg::ST_WAKE;
                end
            end
            scsfw_pkg::ST_WAKE_SHORT: begin
                if (hold_done) begin
                    state_d = sfast_q ? scsfw_pkg::ST_FAST
                                      : scsfw_pkg::ST_RUN;
                end
            end
            scsfw_pkg::ST_FAST: begin
                if (high_rdy) begin
                    state_d = scsfw_pkg::ST_RUN;
                end
            end
            scsfw_pkg::ST_WAKE: begin
                if (tgt_high ? high_rdy : low_rdy) begin
                    state_d = scsfw_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = scsfw_pkg::ST_RUN;
            end
        endcase
    end

    // Source follows the sequencer; no clock while restarting, except a short wake from ST_CPU_OFF_SYSCLK_ON_MODE keeps src_q
    always_comb begin
        case (state_d)
            scsfw_pkg::ST_RUN: begin
                src_d = (tgt_high & high_rdy) ? scsfw_pkg::SRC_HIGH
                                              : scsfw_pkg::SRC_LOW;
            end
            scsfw_pkg::ST_FAST: begin
                src_d = scsfw_pkg::SRC_SUB;
            end
            scsfw_pkg::ST_CPU_OFF_SYSCLK_ON_MODE: begin
                src_d = src_q;
            end
            scsfw_pkg::ST_WAKE_SHORT: begin
                src_d = sfast_d ? scsfw_pkg::SRC_NONE : src_q;
            end
            default: begin
                src_d = scsfw_pkg::SRC_NONE;
            end
        endcase
    end

    wire run_d = state_d == scsfw_pkg::ST_RUN
               || state_d == scsfw_pkg::ST_FAST;
    wire hen_d = (run_d && tgt_high)
               || ((state_d == scsfw_pkg::ST_CPU_OFF_SYSCLK_ON_MODE || (state_d
                    == scsfw_pkg::ST_WAKE_SHORT && !sfast_d))
                   && src_d == scsfw_pkg::SRC_HIGH)
               || (state_d == scsfw_pkg::ST_WAKE_SHORT && sfast_d)
               || (state_d == scsfw_pkg::ST_WAKE && tgt_high);
    wire len_d = state_d != scsfw_pkg::ST_FULL_STOP_MODE;

    // Set wins over a clear in the same cycle
    wire [NEV-1:0] ev;
    assign ev[`SCSFW_EV_HRDY] = high_rdy & ~hrdy_p_q;
    assign ev[`SCSFW_EV_LRDY] = low_rdy & ~lrdy_p_q;
    assign ev[`SCSFW_EV_HALT] = halt_go;
    assign ev[`SCSFW_EV_WAKE] = ~in_run & ~run_d ? 1'b0
                              : (state_q != scsfw_pkg::ST_RUN
                                 && state_q != scsfw_pkg::ST_FAST
                                 && run_d);
    wire [NEV-1:0] clr    = (wr_lo & sel_cl) ? wd[NEV-1:0] : '0;
    wire [NEV-1:0] stat_d = (stat_q & ~clr) | ev;
    wire [NEV-1:0] en_d   = (wr_lo & sel_en) ? wd[NEV-1:0] : en_q;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_q  <= scsfw_pkg::ST_RUN;
            src_q    <= scsfw_pkg::SRC_LOW;
            sfast_q  <= 1'b0;
            div_q    <= 3'h0;
            hen_q    <= 1'b1;
            len_q    <= 1'b1;
            cpu_q    <= 1'b1;
            sclk_q   <= 1'b1;
            hrdy_p_q <= 1'b0;
            lrdy_p_q <= 1'b0;
            stat_q   <= '0;
            irq_q    <= 1'b0;
        end else if (CE) begin
            state_q  <= state_d;
            src_q    <= src_d;
            sfast_q  <= sfast_d;
            div_q    <= shift_d;
            hen_q    <= hen_d;
            len_q    <= len_d;
            cpu_q    <= run_d;
            sclk_q   <= src_d != scsfw_pkg::SRC_NONE;
            hrdy_p_q <= high_rdy;
            lrdy_p_q <= low_rdy;
            stat_q   <= stat_d;
            irq_q    <= |(stat_d & en_d);
        end
    end

    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign SYS_CLK_SRC     = src_q;
    assign SYS_DIV_SHIFT   = div_q;
    assign HIGH_OSC_EN     = hen_q;
    assign LOW_OSC_EN      = len_q;
    assign CPU_RUN         = cpu_q;
    assign SYS_CLK_RUN     = sclk_q;
    assign MODE_STATE      = state_q;
    assign IRQ             = irq_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_div_sel;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        !hsel && div_hi |=> div_q == 3'(8 - $past(cks));
    endproperty
    a_div_sel: assert property (p_div_sel)
        else $error("divider shift wrong");

    property p_hsel;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        in_run && hsel && high_rdy && !HALT_REQ
            |=> src_q == scsfw_pkg::SRC_HIGH && div_q == 3'h0;
    endproperty
    a_hsel: assert property (p_hsel)
        else $error("undivided high clock not selected");

    property p_low_stop;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        in_run && !tgt_high && !HALT_REQ |=> !hen_q ##1 !high_rdy;
    endproperty
    a_low_stop: assert property (p_low_stop)
        else $error("high oscillator left running");

    property p_fast_xtal;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        state_q == scsfw_pkg::ST_FAST |-> is_xtal && hen_q;
    endproperty
    a_fast_xtal: assert property (p_fast_xtal)
        else $error("fast wake on non-crystal");

    property p_lrdy_stop;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        (state_q == scsfw_pkg::ST_FULL_STOP_MODE) [*3] |-> !low_rdy;
    endproperty
    a_lrdy_stop: assert property (p_lrdy_stop)
        else $error("low ready set in full stop");

    property p_hrdy_off;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        (state_q inside {scsfw_pkg::ST_CPU_OFF_SYSCLK_OFF_MODE, scsfw_pkg::ST_FULL_STOP_MODE,
                         scsfw_pkg::ST_STOP_WITH_SUB_CLOCK_MODE}) [*3] |-> !high_rdy;
    endproperty
    a_hrdy_off: assert property (p_hrdy_off)
        else $error("high ready set while stopped");

    property p_idle;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        halt_go && idle_on |=> state_q == ($past(keep) ? scsfw_pkg::ST_CPU_OFF_SYSCLK_ON_MODE
                                                       : scsfw_pkg::ST_CPU_OFF_SYSCLK_OFF_MODE)
                               && cpu_q == 1'b0 && sclk_q == $past(keep);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle entry wrong");

    property p_sleep;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        halt_go && !idle_on |=> state_q == ($past(wdt_en)
            ? scsfw_pkg::ST_STOP_WITH_SUB_CLOCK_MODE : scsfw_pkg::ST_FULL_STOP_MODE) && !sclk_q;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep entry wrong");

    property p_stop_nofast;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        state_q == scsfw_pkg::ST_FULL_STOP_MODE && WAKE_REQ
            |=> state_q == scsfw_pkg::ST_WAKE;
    endproperty
    a_stop_nofast: assert property (p_stop_nofast)
        else $error("fast wake from full stop");

    property p_fast_end;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        state_q == scsfw_pkg::ST_FAST && high_rdy
            |=> in_run && src_q == scsfw_pkg::SRC_HIGH;
    endproperty
    a_fast_end: assert property (p_fast_end)
        else $error("no switch to crystal");

    property p_ro_bits;
        @(posedge CLK_SYS) disable iff (!RST_N || !CE)
        wr_lo && sel_md |=> mode_q == {$past(wd[7:4]), 2'b00,
                                       $past(wd[1:0])};
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("mode register write wrong");
endmodule
`default_nettype wire

// ---- test/scsfw_osc_model.sv ----
// Oscillator sources driving the clock block pins
`timescale 1ns/1ps
`default_nettype none
module scsfw_osc_model (
    // Clock and enables
    input  wire logic clk,
    input  wire logic high_en,
    input  wire logic low_en,
    // Oscillator pins
    output logic      high_osc,
    output logic      low_osc
);
    int hc = 0;
    int lc = 0;
    always @(posedge clk) begin
        hc <= high_en ? (hc + 1) % 4 : 0;
        lc <= low_en ? (lc + 1) % 6 : 0;
    end
    assign high_osc = hc >= 2;
    assign low_osc  = lc >= 3;
endmodule
`default_nettype wire

// ---- test/scsfw_top_test.sv ----
// Self-checking bench for the clock select block
`timescale 1ns/1ps
`default_nettype none
module scsfw_top_test;
    logic        CLK_SYS = 0, RST_N = 0, CE = 1;
    logic [4:0]  AVS_ADDRESS = 0;
    logic        AVS_READ = 0, AVS_WRITE = 0, HALT_REQ = 0, WAKE_REQ = 0;
    logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, rd;
    logic        AVS_WAITREQUEST, OSC_HIGH_IN, OSC_LOW_IN, HIGH_OSC_EN;
    logic [1:0]  SYS_CLK_SRC;
    logic [2:0]  SYS_DIV_SHIFT, MODE_STATE;
    logic        LOW_OSC_EN, CPU_RUN, SYS_CLK_RUN, IRQ;
    logic [7:0]  d;
    logic [3:0]  be = 4'hf;
    logic [1:0]  hk = 2'h0;
    logic        lk = 1'b1;
    int          failures = 0, num_checks = 0, mode_m = 3;
    int          seed = 32'ha8bfcb1a;
    scsfw_top scsfw_top_inst (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(be), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .HALT_REQ(HALT_REQ),
        .WAKE_REQ(WAKE_REQ), .OSC_HIGH_IN(OSC_HIGH_IN),
        .OSC_LOW_IN(OSC_LOW_IN), .HIGH_OSC_KIND(hk),
        .LOW_OSC_KIND(lk), .SYS_CLK_SRC(SYS_CLK_SRC),
        .SYS_DIV_SHIFT(SYS_DIV_SHIFT), .HIGH_OSC_EN(HIGH_OSC_EN),
        .LOW_OSC_EN(LOW_OSC_EN), .CPU_RUN(CPU_RUN),
        .SYS_CLK_RUN(SYS_CLK_RUN), .MODE_STATE(MODE_STATE), .IRQ(IRQ));
    scsfw_osc_model scsfw_osc_model_inst (
        .clk(CLK_SYS), .high_en(HIGH_OSC_EN), .low_en(LOW_OSC_EN),
        .high_osc(OSC_HIGH_IN), .low_osc(OSC_LOW_IN));
    initial forever #20 CLK_SYS = ~CLK_SYS;
    // ****************
    // Shared tasks
    // ****************
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] v);
        int n;
        n = 0;
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= {24'h0, v};
        AVS_WRITE     <= w;
        AVS_READ      <= !w;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
        if (w && a == 5'h00 && be[0])
            mode_m = v & 8'hf3;
        @(posedge CLK_SYS);
        if (n == 40) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic wfor(input logic [4:0] v);
        int n;
        n = 0;
        while ({SYS_CLK_SRC, MODE_STATE} !== v && n < 8000) begin
            @(posedge CLK_SYS);
            n++;
        end
        chk(32'({SYS_CLK_SRC, MODE_STATE}), 32'(v));
        if (n == 8000)
            stop_test();
    endtask
    task automatic pulse(input logic h);
        HALT_REQ <= h;
        WAKE_REQ <= !h;
        @(posedge CLK_SYS);
        HALT_REQ <= 1'b0;
        WAKE_REQ <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (20) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        bus(1'b0, 5'h00, 8'h00);
        chk(rd, 32'h03);
        wfor(5'h00);
        chk(32'(IRQ), 32'h0);
        d = 8'($random(seed)) & 8'hf3 | 8'h01;
        bus(1'b1, 5'h00, d | 8'h0c);
        bus(1'b0, 5'h00, 8'h00);
        chk(rd, 32'(mode_m) | 32'h0c);
        chk(32'(SYS_DIV_SHIFT), 32'h0);
        for (int i = 7; i >= 0; i--) begin
            bus(1'b1, 5'h00, {i[2:0], 5'h02});
            repeat (2) @(posedge CLK_SYS);
            if (i >= 2) begin
                chk(32'(SYS_DIV_SHIFT), 32'(8 - i));
                chk(32'(SYS_CLK_SRC), 32'h0);
            end
        end
        wfor(5'h08);
        chk(32'(HIGH_OSC_EN), 32'h0);
        bus(1'b0, 5'h00, 8'h00);
        chk(rd, 32'(mode_m) | 32'h08);
        bus(1'b1, 5'h08, 8'h04);
        bus(1'b1, 5'h10, 8'h02);
        bus(1'b1, 5'h00, 8'h13);
        wfor(5'h00);
        pulse(1'b1);
        chk(32'({MODE_STATE, CPU_RUN, SYS_CLK_RUN, IRQ}), 32'h9);
        bus(1'b0, 5'h04, 8'h00);
        chk(rd, 32'h07);
        bus(1'b0, 5'h00, 8'h00);
        chk(rd & 32'h04, 32'h0);
        bus(1'b1, 5'h0c, 8'h04);
        chk(32'(IRQ), 32'h0);
        bus(1'b0, 5'h04, 8'h00);
        chk(rd, 32'h03);
        pulse(1'b0);
        chk(32'(MODE_STATE), 32'h6);
        wfor(5'h17);
        chk(32'(CPU_RUN), 32'h1);
        wfor(5'h00);
        bus(1'b1, 5'h10, 8'h03);
        pulse(1'b1);
        chk(32'({MODE_STATE, SYS_CLK_RUN}), 32'h5);
        pulse(1'b0);
        wfor(5'h00);
        bus(1'b1, 5'h10, 8'h00);
        bus(1'b1, 5'h00, 8'h11);
        pulse(1'b1);
        chk(32'({MODE_STATE, LOW_OSC_EN}), 32'h6);
        bus(1'b0, 5'h00, 8'h00);
        chk(rd, 32'(mode_m));
        bus(1'b0, 5'h14, 8'h00);
        chk(rd, 32'h1b);
        pulse(1'b0);
        chk(32'(MODE_STATE), 32'h5);
        wfor(5'h00);
        bus(1'b0, 5'h04, 8'h00);
        chk(rd, 32'h0f);
        hk <= 2'h1;
        bus(1'b1, 5'h10, 8'h02);
        pulse(1'b1);
        chk(32'(MODE_STATE), 32'h4);
        pulse(1'b0);
        chk(32'(MODE_STATE), 32'h5);
        wfor(5'h00);
        lk <= 1'b0;
        bus(1'b1, 5'h10, 8'h00);
        bus(1'b1, 5'h00, 8'h10);
        pulse(1'b1);
        pulse(1'b0);
        wfor(5'h08);
        be <= 4'h0;
        bus(1'b1, 5'h00, 8'h00);
        be <= 4'hf;
        bus(1'b0, 5'h00, 8'h00);
        chk(rd, 32'(mode_m) | 32'h08);
        bus(1'b0, 5'h18, 8'h00);
        chk(rd, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
